/* src/can_tx_history_timestamp.sv */
// Function
// - History read returns list element at read pointer in the upper byte.
// - Pointer-match reads 0 while unread entries remain, else 1.
// - Without overflow, every recorded transmission is appended to a free element; on a full list it overwrites element before write pointer.
// - Overflow sets at seven entries; later numbers overwrite element before write pointer.
// - In overflow a transmission keeps pointer-match; reading all entries still sets it.
// - With auto block transmit, buffers 0 to 7 are not recorded.
// - Writing 1 to bit 0 of history register clears overflow.
// - Stamp control bits use set/clear pairs at 10..8 and 2..0.
// - Stamp enable lets the output toggle on each capture event.
// - Event select: 0 start of frame, 1 last bit of end of frame.
// - Lock freezes the output after a good data frame into buffer 0.
// - A taken lock clears the stamp enable bit.
// - The toggle output is a port towards a timer.
// - Eight data bytes per buffer, also reachable as four 16-bit pairs.
// - Last-out register shows the most recently transmitting buffer.
// - History register low byte resets to match 1, overflow 0.
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`include "can_tx_hist_defines.svh"
module can_tx_history_timestamp (
    // Clock and reset
    input  wire logic                       clk_i,
    input  wire logic                       rstn_i,
    // APB slave
    input  wire logic                       psel_i,
    input  wire logic                       penable_i,
    input  wire logic                       pwrite_i,
    input  wire can_tx_hist_pkg::apb_addr_t paddr_i,
    input  wire can_tx_hist_pkg::apb_data_t pwdata_i,
    input  wire logic [3:0]                 pstrb_i,
    output can_tx_hist_pkg::apb_data_t      prdata_o,
    output logic                            pready_o,
    output logic                            pslverr_o,
    // Protocol engine events
    input  wire logic                       tx_done_i,
    input  wire can_tx_hist_pkg::buf_num_t  tx_buf_i,
    input  wire logic                       auto_block_transmit_i,
    input  wire logic                       sof_i,
    input  wire logic                       eof_last_i,
    input  wire logic                       rx_buf0_ok_i,
    // Outputs
    output logic                            stamp_toggle_out_o,
    output logic                            irq_o
);
    import can_tx_hist_pkg::*;

    function automatic hist_idx_t idx_next(input hist_idx_t p);
        idx_next = (p == `HIST_LAST_IDX) ? 3'h0 : p + 3'h1;
    endfunction

    function automatic hist_idx_t idx_prev(input hist_idx_t p);
        idx_prev = (p == 3'h0) ? `HIST_LAST_IDX : p - 3'h1;
    endfunction

    function automatic logic set_clear(input logic cur, input logic s, input logic c);
        set_clear = (s && !c) ? 1'b1 : ((!s && c) ? 1'b0 : cur);
    endfunction

    // Bus decode
    logic       access;
    logic       done;
    logic       wr_fire;
    logic       rd_fire;
    logic       hist_hit;
    logic       lout_hit;
    logic       ts_hit;
    logic       stat_hit;
    logic       mask_hit;
    logic       byte_hit;
    logic       pair_hit;
    logic       mapped;
    logic [6:0] byte_idx;
    logic [6:0] pair_idx;

    assign access   = psel_i && penable_i;
    assign done     = access && pready_o;
    assign wr_fire  = done && pwrite_i;
    assign rd_fire  = done && !pwrite_i;
    assign hist_hit = paddr_i == `IDX_TO_ADDR(`HIST_READ_IDX);
    assign lout_hit = paddr_i == `IDX_TO_ADDR(`LAST_OUT_IDX);
    assign ts_hit   = paddr_i == `IDX_TO_ADDR(`TS_IDX);
    assign stat_hit = paddr_i == `IRQ_STAT_ADDR;
    assign mask_hit = paddr_i == `IRQ_MASK_ADDR;
    assign byte_hit = (paddr_i[17:9] == `BYTE_REGION) && (paddr_i[1:0] == 2'h0);
    assign pair_hit = (paddr_i[17:8] == `PAIR_REGION) && (paddr_i[1:0] == 2'h0);
    assign mapped   = hist_hit || lout_hit || ts_hit || stat_hit || mask_hit || byte_hit || pair_hit;
    assign byte_idx = paddr_i[8:2];
    assign pair_idx = {paddr_i[7:4], paddr_i[3:2], 1'b0};

    // History list state
    buf_num_t  hist [7];
    hist_idx_t rd_ptr;
    hist_idx_t wr_ptr;
    logic [2:0] count;
    logic       ovf;
    buf_num_t   last_out;
    logic       ptr_match;
    logic       hist_store;
    logic       hist_pop;
    logic       ovf_set;
    logic       ovf_clr;
    hist_idx_t  store_idx;
    logic       full;
    logic       room;

    assign ptr_match  = count == 3'h0;
    assign full       = count == `HIST_DEPTH;
    // In-order slot only without overflow and with space; a full list
    // after a bare overflow clear must not wrap the count
    assign room       = !ovf && !(full && !hist_pop);
    assign hist_store = tx_done_i && !(auto_block_transmit_i && tx_buf_i <= `BLOCK_LAST_BUF);
    // Pop follows the match flag the reader was shown, so an entry stored
    // between data capture and completion is not lost
    assign hist_pop   = rd_fire && hist_hit && !prdata_o[`HIST_PM_BIT];
    assign ovf_set    = hist_store && !ovf && !hist_pop && (count == `HIST_OVF_FILL || full);
    assign ovf_clr    = wr_fire && hist_hit && pwdata_i[`HIST_OVF_BIT];
    assign store_idx  = room ? wr_ptr : idx_prev(wr_ptr);

    always_ff @(posedge clk_i) begin
        if (hist_store) begin
            hist[store_idx] <= tx_buf_i;
        end
    end

    // Overflow stores leave pointer and count alone, so match stays as it was
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wr_ptr <= 3'h0;
            rd_ptr <= 3'h0;
            count  <= 3'h0;
        end else begin
            if (hist_store && room) begin
                wr_ptr <= idx_next(wr_ptr);
            end
            if (hist_pop) begin
                rd_ptr <= idx_next(rd_ptr);
            end
            count <= count + {2'h0, hist_store && room} - {2'h0, hist_pop};
        end
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ovf <= 1'b0;
        end else if (ovf_set) begin
            ovf <= 1'b1;
        end else if (ovf_clr) begin
            ovf <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            last_out <= 4'h0;
        end else if (tx_done_i) begin
            last_out <= tx_buf_i;
        end
    end

    // Time stamp control
    logic [2:0] ts_ctrl;
    logic [2:0] next_ts_ctrl;
    logic       lock_hit;

    assign lock_hit = ts_ctrl[`TS_LOCK_BIT] && rx_buf0_ok_i;

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_ts
            logic written;
            assign written = (wr_fire && ts_hit)
                           ? set_clear(ts_ctrl[g], pwdata_i[g + `TS_SET_SHIFT], pwdata_i[g])
                           : ts_ctrl[g];
            // Hardware clear of enable wins over a simultaneous software set
            assign next_ts_ctrl[g] = (g == `TS_EN_BIT && lock_hit) ? 1'b0 : written;
        end
    endgenerate

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ts_ctrl <= `TS_RESET;
        end else begin
            ts_ctrl <= next_ts_ctrl;
        end
    end

    stamp_toggle u_stamp_toggle (
        .clk_i      (clk_i),
        .rstn_i     (rstn_i),
        .enable_i   (ts_ctrl[`TS_EN_BIT]),
        .select_i   (ts_ctrl[`TS_SEL_BIT]),
        .freeze_i   (lock_hit),
        .sof_i      (sof_i),
        .eof_last_i (eof_last_i),
        .toggle_o   (stamp_toggle_out_o)
    );

    // Message data bytes, no reset by design
    data_byte_t msg [128];

    always_ff @(posedge clk_i) begin
        if (wr_fire && byte_hit && pstrb_i[0]) begin
            msg[byte_idx] <= pwdata_i[7:0];
        end
        if (wr_fire && pair_hit && pstrb_i[0]) begin
            msg[pair_idx] <= pwdata_i[7:0];
        end
        if (wr_fire && pair_hit && pstrb_i[1]) begin
            msg[pair_idx + 7'h1] <= pwdata_i[15:8];
        end
    end

    // Interrupts: history entry, overflow, lock taken
    irq_vec_t irq_stat;
    irq_vec_t irq_mask;
    irq_vec_t irq_evt;
    irq_vec_t irq_w1c;

    assign irq_evt = {lock_hit, ovf_set, hist_store};
    assign irq_w1c = (wr_fire && stat_hit) ? pwdata_i[2:0] : 3'h0;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            irq_stat <= `IRQ_RESET;
            irq_mask <= `IRQ_RESET;
            irq_o    <= 1'b0;
        end else begin
            irq_stat <= irq_evt | (irq_stat & ~irq_w1c);
            if (wr_fire && mask_hit) begin
                irq_mask <= pwdata_i[2:0];
            end
            irq_o <= |(irq_stat & irq_mask);
        end
    end

    // Read mux
    apb_data_t rd_word;
    apb_data_t hist_word;

    assign hist_word = {16'h0, 4'h0, hist[rd_ptr], 6'h0, ptr_match, ovf};
    assign rd_word   = hist_hit ? hist_word
                     : lout_hit ? {28'h0, last_out}
                     : ts_hit   ? {29'h0, ts_ctrl}
                     : stat_hit ? {29'h0, irq_stat}
                     : mask_hit ? {29'h0, irq_mask}
                     : byte_hit ? {24'h0, msg[byte_idx]}
                     : pair_hit ? {16'h0, msg[pair_idx + 7'h1], msg[pair_idx]}
                     : 32'h0;

    // One wait state; read data captured while the request is held
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0;
        end else begin
            pready_o  <= access && !pready_o;
            pslverr_o <= access && !pready_o && !mapped;
            if (access && !pready_o && !pwrite_i) begin
                prdata_o <= rd_word;
            end
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    hist_read_a: assert property (access && !pready_o && !pwrite_i && hist_hit && !ptr_match |=>
        prdata_o[15:8] == {4'h0, $past(hist[rd_ptr])}) else $error("history read data wrong");
    ptr_match_a: assert property (access && !pready_o && !pwrite_i && hist_hit |=>
        prdata_o[1] == $past(count == 3'h0)) else $error("pointer match wrong");
    hist_store_a: assert property (hist_store && room && !hist_pop |=>
        count == $past(count) + 3'h1 && hist[$past(wr_ptr)] == $past(tx_buf_i)) else $error("store lost");
    ovf_set_a: assert property (ovf_set |=> ovf && count == `HIST_DEPTH) else $error("overflow not set");
    ovf_store_a: assert property (ovf && hist_store && !hist_pop |=>
        wr_ptr == $past(wr_ptr) && count == $past(count)) else $error("overflow store moved pointer");
    block_skip_a: assert property (tx_done_i && auto_block_transmit_i && tx_buf_i <= `BLOCK_LAST_BUF
        && !hist_pop |=> $stable(count) && $stable(wr_ptr)) else $error("block buffer recorded");
    ovf_clear_a: assert property (ovf_clr && !ovf_set |=> !ovf) else $error("overflow not cleared");
    ts_set_a: assert property (wr_fire && ts_hit && pwdata_i[9] && !pwdata_i[1] |=>
        ts_ctrl[`TS_SEL_BIT]) else $error("select not set");
    toggle_a: assert property (ts_ctrl[`TS_EN_BIT] && !lock_hit && (ts_ctrl[`TS_SEL_BIT] ? eof_last_i : sof_i)
        |=> stamp_toggle_out_o != $past(stamp_toggle_out_o)) else $error("no toggle");
    hold_a: assert property (lock_hit |=> !ts_ctrl[`TS_EN_BIT] && $stable(stamp_toggle_out_o) [*2])
        else $error("lock did not hold output");
    last_out_a: assert property (tx_done_i |=> last_out == $past(tx_buf_i)) else $error("last out wrong");
    irq_a: assert property (|(irq_stat & irq_mask) |=> irq_o) else $error("interrupt missing");

    // Bus handshake: exactly one wait state, error only off the map
    wait_state_a: assert property (access && !pready_o
        |=> pready_o) else $error("wait state wrong");
    ready_pulse_a: assert property (pready_o
        |=> !pready_o) else $error("ready held too long");
    slave_err_a: assert property (access && !pready_o
        |=> pslverr_o == !$past(mapped)) else $error("error response wrong");
    prdata_keep_a: assert property (!(access && !pready_o && !pwrite_i)
        |=> $stable(prdata_o)) else $error("read data moved");

    // History list
    full_hold_a: assert property (hist_store && full && !ovf && !hist_pop |=>
        ovf && count == `HIST_DEPTH && $stable(wr_ptr)) else $error("full list wrapped");
    ovf_keep_a: assert property (ovf && !ovf_clr
        |=> ovf) else $error("overflow lost");
    drain_match_a: assert property (hist_pop && count == 3'h1 && !(hist_store && room)
        |=> ptr_match) else $error("match not set after drain");
    ovf_match_a: assert property (ovf && ptr_match
        |=> ptr_match) else $error("match cleared in overflow");
    last_keep_a: assert property (!tx_done_i
        |=> $stable(last_out)) else $error("last out moved");

    // Time stamp control
    ts_clear_a: assert property (wr_fire && ts_hit && !pwdata_i[`TS_EN_BIT + `TS_SET_SHIFT]
        && pwdata_i[`TS_EN_BIT] |=> !ts_ctrl[`TS_EN_BIT]) else $error("enable not cleared");
    ts_keep_a: assert property (wr_fire && ts_hit
        && pwdata_i[`TS_LOCK_BIT + `TS_SET_SHIFT] == pwdata_i[`TS_LOCK_BIT] |=> $stable(ts_ctrl[`TS_LOCK_BIT]))
        else $error("lock changed without a set or clear");
    sel_keep_a: assert property (!(wr_fire && ts_hit)
        |=> $stable(ts_ctrl[`TS_SEL_BIT])) else $error("select changed without a write");
    idle_hold_a: assert property (!ts_ctrl[`TS_EN_BIT]
        |=> $stable(stamp_toggle_out_o)) else $error("toggled while disabled");

    // Interrupts and message data
    irq_low_a: assert property (!(|(irq_stat & irq_mask))
        |=> !irq_o) else $error("interrupt stuck");
    stat_set_a: assert property (hist_store
        |=> irq_stat[`IRQ_TX_BIT]) else $error("entry event lost");
    stat_clear_a: assert property (wr_fire && stat_hit && pwdata_i[`IRQ_TX_BIT] && !hist_store
        |=> !irq_stat[`IRQ_TX_BIT]) else $error("status not cleared");
    mask_write_a: assert property (wr_fire && mask_hit
        |=> irq_mask == $past(pwdata_i[2:0])) else $error("mask write lost");
    byte_write_a: assert property (wr_fire && byte_hit && pstrb_i[0] |=>
        msg[$past(byte_idx)] == $past(pwdata_i[7:0])) else $error("data byte write lost");
    pair_write_a: assert property (wr_fire && pair_hit && pstrb_i[1] |=>
        msg[$past(pair_idx) + 7'h1] == $past(pwdata_i[15:8])) else $error("pair high byte wrong");

    fill_c: cover property (ovf_set);
    lock_c: cover property (lock_hit ##1 !ts_ctrl[`TS_EN_BIT]);
    drain_c: cover property (ovf && hist_pop && count == 3'h1 ##1 ptr_match);
    pair_c: cover property (wr_fire && pair_hit && pstrb_i[1:0] == 2'h3);
    ovf_store_c: cover property (ovf && hist_store);
endmodule // can_tx_history_timestamp

/* src/can_tx_hist_defines.svh */
`ifndef CAN_TX_HIST_DEFINES_SVH
`define CAN_TX_HIST_DEFINES_SVH

// Register indices; byte address is four times the index
`define HIST_READ_IDX   16'hFF62
`define LAST_OUT_IDX    16'hFF68
`define TS_IDX          16'hFF8A
`define IDX_TO_ADDR(i)  {(i), 2'b00}

// Own register map
`define IRQ_STAT_ADDR   18'h00800
`define IRQ_MASK_ADDR   18'h00804
`define BYTE_REGION     9'h000
`define PAIR_REGION     10'h004

// History list geometry
`define HIST_DEPTH      3'h7
`define HIST_LAST_IDX   3'h6
`define HIST_OVF_FILL   3'h6
`define BLOCK_LAST_BUF  4'h7

// Field positions
`define HIST_OVF_BIT    0
`define HIST_PM_BIT     1
`define TS_EN_BIT       0
`define TS_SEL_BIT      1
`define TS_LOCK_BIT     2
`define TS_SET_SHIFT    8
`define IRQ_TX_BIT      0
`define IRQ_OVF_BIT     1
`define IRQ_LOCK_BIT    2

// Reset values
`define TS_RESET        3'h0
`define IRQ_RESET       3'h0

`endif

/* src/can_tx_hist_pkg.sv */
package can_tx_hist_pkg;
    typedef logic [3:0]  buf_num_t;
    typedef logic [2:0]  hist_idx_t;
    typedef logic [7:0]  data_byte_t;
    typedef logic [17:0] apb_addr_t;
    typedef logic [31:0] apb_data_t;
    typedef logic [2:0]  irq_vec_t;
endpackage

/* src/stamp_toggle.sv */
`timescale 1ns/1ps
module stamp_toggle (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rstn_i,
    // Control
    input  wire logic enable_i,
    input  wire logic select_i,
    input  wire logic freeze_i,
    // Capture events
    input  wire logic sof_i,
    input  wire logic eof_last_i,
    // Toggle output
    output logic      toggle_o
);
    logic capture;

    assign capture = select_i ? eof_last_i : sof_i;

    // Freeze keeps the level seen at the moment of the lock
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            toggle_o <= 1'b0;
        end else if (enable_i && capture && !freeze_i) begin
            toggle_o <= ~toggle_o;
        end
    end
endmodule // stamp_toggle

/* tb/can_node_model.sv */
`timescale 1ns/1ps
module can_node_model (
    // Clock
    input  wire logic                 clk_i,
    // Frame events seen by the controller
    output logic                      tx_done_o,
    output can_tx_hist_pkg::buf_num_t tx_buf_o,
    output logic                      sof_o,
    output logic                      eof_last_o,
    output logic                      rx_buf0_ok_o
);
    import can_tx_hist_pkg::*;
    initial begin
        {tx_done_o, sof_o, eof_last_o, rx_buf0_ok_o} = 4'h0;
        tx_buf_o = 4'h0;
    end
    // One finished transmission, number valid only with the strobe
    task automatic send(input buf_num_t b);
        @(posedge clk_i);
        tx_done_o <= 1'b1;
        tx_buf_o  <= b;
        @(posedge clk_i);
        tx_done_o <= 1'b0;
        tx_buf_o  <= ~b;
    endtask
    // Order: start of frame, last bit of end of frame, good frame in buffer 0
    task automatic ev(input logic [2:0] e);
        @(posedge clk_i);
        {sof_o, eof_last_o, rx_buf0_ok_o} <= e;
        @(posedge clk_i);
        {sof_o, eof_last_o, rx_buf0_ok_o} <= 3'h0;
    endtask
endmodule // can_node_model

/* tb/can_tx_history_timestamp_bench.sv */
`timescale 1ns/1ps
`include "can_tx_hist_defines.svh"
module can_tx_history_timestamp_bench;
    import can_tx_hist_pkg::*;
    localparam apb_addr_t HIST = `IDX_TO_ADDR(`HIST_READ_IDX);
    localparam apb_addr_t LOUT = `IDX_TO_ADDR(`LAST_OUT_IDX);
    localparam apb_addr_t STMP = `IDX_TO_ADDR(`TS_IDX);
    logic      clk = 1'b0;
    logic      rstn = 1'b0;
    logic      psel = 1'b0;
    logic      penable = 1'b0;
    logic      pwrite = 1'b0;
    apb_addr_t paddr = 18'h00000;
    apb_data_t pwdata = 32'h0;
    logic [3:0] pstrb = 4'hF;
    logic      auto_block = 1'b0;
    apb_data_t prdata, r;
    logic      pready, pslverr, tx_done, sof, eof_last, rx_ok, tog, irq, er, exp_t;
    buf_num_t  tx_buf;
    int        failures = 0;
    int        n_compared = 0;

    always #5 clk = ~clk;

    can_node_model node_u (.clk_i(clk), .tx_done_o(tx_done), .tx_buf_o(tx_buf), .sof_o(sof),
        .eof_last_o(eof_last), .rx_buf0_ok_o(rx_ok));
    can_tx_history_timestamp dut_u (.clk_i(clk), .rstn_i(rstn), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .tx_done_i(tx_done), .tx_buf_i(tx_buf),
        .auto_block_transmit_i(auto_block), .sof_i(sof), .eof_last_i(eof_last), .rx_buf0_ok_i(rx_ok),
        .stamp_toggle_out_o(tog), .irq_o(irq));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input apb_addr_t a, input apb_data_t d, input logic [3:0] s,
                       output apb_data_t q, output logic e);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input apb_addr_t a, input apb_data_t d);
        apb(1'b1, a, d, 4'hF, r, er);
    endtask

    task automatic rd(input apb_addr_t a);
        apb(1'b0, a, 32'h0, 4'hF, r, er);
    endtask

    // Expected output level is tracked here, never read back from the block
    task automatic stamp(input logic [2:0] e, input logic flip);
        exp_t = exp_t ^ flip;
        node_u.ev(e);
        repeat (2) @(posedge clk);
        check(32'(tog), 32'(exp_t));
    endtask

    task automatic wrap_up;
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        wrap_up();
    end

    initial begin
        exp_t = 1'b0;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        rd(HIST); check(r & 32'hFF, 32'h02);
        rd(STMP); check(r, 32'h0);
        $display("reset values done");

        wr(`IRQ_MASK_ADDR, 32'h1);
        for (int i = 0; i < 3; i++) node_u.send(4'(9 + i));
        repeat (2) @(posedge clk);
        check(32'(irq), 32'h1);
        rd(LOUT); check(r & 32'hF, 32'hB);
        for (int i = 0; i < 3; i++) begin
            rd(HIST); check(r & 32'hFFFF, {20'h0, 4'(9 + i), 8'h00});
        end
        rd(HIST); check(r & 32'hFF, 32'h02);
        wr(`IRQ_STAT_ADDR, 32'h7);
        wr(`IRQ_MASK_ADDR, 32'h0);
        $display("history sequence done");

        // Eight transmissions without a read: the last overwrites the seventh
        for (int i = 1; i <= 8; i++) node_u.send(4'(i));
        repeat (2) @(posedge clk);
        check(32'(irq), 32'h0);
        rd(`IRQ_STAT_ADDR); check(r, 32'h3);
        for (int i = 1; i <= 7; i++) begin
            rd(HIST); check(r & 32'hFFFF, {20'h0, 4'((i == 7) ? 8 : i), 8'h01});
        end
        rd(HIST); check(r & 32'hFF, 32'h03);
        node_u.send(4'hC);
        rd(HIST); check(r & 32'hFF, 32'h03);
        wr(HIST, 32'h0);
        rd(HIST); check(r & 32'hFF, 32'h03);
        wr(HIST, 32'h1);
        rd(HIST); check(r & 32'hFF, 32'h02);
        $display("overflow done");

        auto_block <= 1'b1;
        node_u.send(4'h3);
        rd(HIST); check(r & 32'hFF, 32'h02);
        rd(LOUT); check(r & 32'hF, 32'h3);
        node_u.send(4'hE);
        rd(HIST); check(r & 32'hFFFF, 32'h0E00);
        auto_block <= 1'b0;
        $display("auto block transmit done");

        wr(STMP, 32'h0100);
        rd(STMP); check(r, 32'h1);
        stamp(3'b100, 1'b1);
        stamp(3'b010, 1'b0);
        stamp(3'b001, 1'b0);
        wr(STMP, 32'h0200);
        stamp(3'b010, 1'b1);
        stamp(3'b100, 1'b0);
        wr(STMP, 32'h0303);
        rd(STMP); check(r, 32'h3);
        wr(STMP, 32'h0001);
        stamp(3'b010, 1'b0);
        wr(STMP, 32'h0500);
        rd(STMP); check(r, 32'h7);
        stamp(3'b011, 1'b0);
        rd(STMP); check(r, 32'h6);
        rd(`IRQ_STAT_ADDR); check(r & 32'h4, 32'h4);
        stamp(3'b010, 1'b0);
        wr(STMP, 32'h0004);
        rd(STMP); check(r, 32'h2);
        $display("time stamp done");

        for (int b = 0; b < 8; b++) wr(18'(32'hA0 + 4 * b), 32'(8'h30 + b));
        for (int p = 0; p < 4; p++) begin
            rd(18'(32'h450 + 4 * p)); check(r & 32'hFFFF, {16'h0, 8'(8'h31 + 2 * p), 8'(8'h30 + 2 * p)});
        end
        apb(1'b1, 18'h00450, 32'hAB55, 4'h1, r, er);
        rd(18'h000A0); check(r & 32'hFF, 32'h55);
        rd(18'h000A4); check(r & 32'hFF, 32'h31);
        apb(1'b0, 18'h00300, 32'h0, 4'hF, r, er);
        check({r[30:0], er}, 32'h1);
        $display("data bytes done");
        wrap_up();
    end
endmodule // can_tx_history_timestamp_bench
